// ==== rtl/spc_pkg.sv ====
// Package: register map, field layout and types of the sleep and power control block
package spc_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam int          ADDR_W            = 8;
  localparam logic [7:0]  OFF_SLEEP_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_CLK_GATE0     = 8'h04;
  localparam logic [7:0]  OFF_IN_DIS0       = 8'h08;
  localparam logic [7:0]  OFF_IN_DIS1       = 8'h0c;
  localparam logic [7:0]  OFF_MCU_CTRL      = 8'h10;
  localparam logic [7:0]  OFF_STATUS        = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          SLEEP_ARM_BIT     = 0;
  localparam int          SLEEP_MODE_LSB    = 1;
  localparam int          SLEEP_MODE_MSB    = 3;
  localparam int          GATE_TWO_WIRE_BIT = 7;
  localparam int          GATE_RESERVED_BIT = 6;
  localparam int          DEBUG_DISABLE_BIT = 7;
  localparam int          ST_SLEEPING_BIT   = 0;
  localparam int          ST_MODE_LSB       = 1;
  localparam int          ST_MODE_MSB       = 3;
  localparam int          ST_DEBUG_BIT      = 4;
  localparam int          ST_EXT_CONV_BIT   = 5;
  localparam int          ST_VREF_BIT       = 6;
  localparam int          ST_TWI_CLK_BIT    = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  RST_SLEEP_CTRL    = 8'h00;
  localparam logic [7:0]  RST_CLK_GATE0     = 8'h00;
  localparam logic [7:0]  RST_IN_DIS        = 8'h00;
  localparam logic [7:0]  RST_MCU_CTRL      = 8'h00;

  // ==========================================================================
  // Sleep mode codes and fuse codes
  // ==========================================================================
  localparam logic [2:0]  MODE_IDLE         = 3'h0;
  localparam logic [2:0]  MODE_ADC_NR       = 3'h1;
  localparam logic [2:0]  MODE_POWER_DOWN   = 3'h2;
  localparam logic [2:0]  MODE_POWER_SAVE   = 3'h3;
  localparam logic [2:0]  MODE_RSVD_A       = 3'h4;
  localparam logic [2:0]  MODE_RSVD_B       = 3'h5;
  localparam logic [2:0]  MODE_STANDBY      = 3'h6;
  localparam logic [2:0]  MODE_EXT_STANDBY  = 3'h7;
  localparam logic [2:0]  BOD_LEVEL_OFF     = 3'h7;

  // ==========================================================================
  // Bus answers
  // ==========================================================================
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic {
    SPC_RUN,
    SPC_SLEEP
  } spc_state_e;

  // Clock domains and the main oscillator
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic main_osc;
  } spc_clocks_s;

  // Analog helpers and supervisors
  typedef struct packed {
    logic adc_power;
    logic adc_extended;
    logic comparator_power;
    logic vref_enable;
    logic brownout_run;
    logic watchdog_run;
  } spc_analog_s;

  // Configuration fuses
  typedef struct packed {
    logic [2:0] brownout_level_fuses;
    logic       debug_enable_fuse;
    logic       scan_port_enable_fuse;
  } spc_fuses_s;

endpackage : spc_pkg

// ==== rtl/spc_pin_gate.sv ====
// Digital input buffer enables for one group of port pins
`timescale 1ns/100ps
`default_nettype none

module spc_pin_gate #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] input_disable,
  input  wire logic         deep_sleep,
  input  wire logic [W-1:0] wake_needed,
  output logic      [W-1:0] buffer_enable
);

  // Software disable always wins, so analog pins never draw crossover current
  assign buffer_enable = ~input_disable & ({W{~deep_sleep}} | wake_needed);

endmodule : spc_pin_gate

`default_nettype wire

// ==== rtl/spc_conv_track.sv ====
// Tracks converter power cycles to request one extended conversion
`timescale 1ns/100ps
`default_nettype none

module spc_conv_track (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic adc_enable,
  input  wire logic conv_start,
  output logic      extended_pending
);

  logic was_on_q;
  logic pend_q;
  logic pend_d;
  logic rise;

  assign rise   = adc_enable & ~was_on_q;
  // A re-enable in the same cycle as a start keeps the request
  assign pend_d = rise | (pend_q & ~conv_start);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_on_q <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      was_on_q <= adc_enable;
      pend_q   <= pend_d;
    end
  end

  assign extended_pending = pend_q;

endmodule : spc_conv_track

`default_nettype wire

// ==== rtl/spc_top.sv ====
// Sleep and power control: mode register, clock gating and analog keep-alive
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Enabled converter stays powered in every sleep mode
// - Converter re-enable makes next conversion extended
// - Comparator auto-off outside Idle and noise reduction
// - Comparator using reference keeps reference on
// - Reference on only when a user needs it
// - Fuse-enabled brown-out detector runs in sleep
// - Enabled watchdog keeps running in all sleep
// - Deep sleep disables digital input buffers
// - Wake-up input logic stays enabled in sleep
// - Input disable bit turns pin buffer off
// - Debug fuse keeps main clock running in sleep
// - Debug off by either fuse or disable bit
// - Mode field bits 3..1 selects sleep mode
// - Sleep entered only when arm bit set
// - Gate bit 7 stops two-wire interface clock
// - Gate register bit 6 reads zero
// - Gated peripheral frozen, register access blocked
// - Power-down halts every generated clock except the main oscillator while debug is active

module spc_top #(
  parameter int PINS0 = 8,
  parameter int PINS1 = 8
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite slave
  input  wire logic [spc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [spc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Core and wake-up side
  input  wire logic                   sleep_instr,
  input  wire logic                   wake_event,
  output logic                        sleep_done,
  // Fuses and peripheral status
  input  wire spc_pkg::spc_fuses_s    fuses,
  input  wire logic                   adc_enable,
  input  wire logic                   adc_uses_ref,
  input  wire logic                   adc_conv_start,
  input  wire logic                   comparator_enable,
  input  wire logic                   comparator_uses_ref,
  input  wire logic                   watchdog_enable,
  input  wire logic [PINS0-1:0]       wake_needed0,
  input  wire logic [PINS1-1:0]       wake_needed1,
  // Power controls
  output spc_pkg::spc_clocks_s        clocks,
  output spc_pkg::spc_analog_s        analog,
  output logic [PINS0-1:0]            pin_buffer_en0,
  output logic [PINS1-1:0]            pin_buffer_en1,
  output logic                        two_wire_clock_en,
  output logic                        two_wire_access_block,
  output logic                        debug_active,
  output logic                        sleeping
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [7:0]                  sleep_ctrl_q;
  logic [7:0]                  clk_gate0_q;
  logic [PINS0-1:0]            in_dis0_q;
  logic [PINS1-1:0]            in_dis1_q;
  logic                        dbg_dis_q;
  spc_pkg::spc_state_e         state_q;
  spc_pkg::spc_state_e         state_d;
  logic [2:0]                  mode_q;
  logic [2:0]                  mode_d;
  logic                        done_q;
  logic                        done_d;

  // ==========================================================================
  // AXI4-Lite write path
  // ==========================================================================
  logic                        aw_full_q;
  logic                        w_full_q;
  logic [spc_pkg::ADDR_W-1:0]  waddr_q;
  logic [7:0]                  wbyte_q;
  logic                        wlane0_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        aw_hs;
  logic                        w_hs;
  logic                        wr_fire;
  logic [spc_pkg::ADDR_W-1:0]  waddr_al;
  logic                        wr_sleep;
  logic                        wr_gate;
  logic                        wr_dis0;
  logic                        wr_dis1;
  logic                        wr_mcu;
  logic                        wr_stat;
  logic                        wr_hit;
  logic                        wr_en;

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign aw_hs         = s_axi_awvalid & s_axi_awready;
  assign w_hs          = s_axi_wvalid & s_axi_wready;
  assign wr_fire       = aw_full_q & w_full_q;
  assign waddr_al      = {waddr_q[spc_pkg::ADDR_W-1:2], 2'b00};

  assign wr_sleep = (waddr_al == spc_pkg::OFF_SLEEP_CTRL);
  assign wr_gate  = (waddr_al == spc_pkg::OFF_CLK_GATE0);
  assign wr_dis0  = (waddr_al == spc_pkg::OFF_IN_DIS0);
  assign wr_dis1  = (waddr_al == spc_pkg::OFF_IN_DIS1);
  assign wr_mcu   = (waddr_al == spc_pkg::OFF_MCU_CTRL);
  assign wr_stat  = (waddr_al == spc_pkg::OFF_STATUS);
  assign wr_hit   = wr_sleep | wr_gate | wr_dis0 | wr_dis1 | wr_mcu | wr_stat;
  // Only byte lane 0 carries register data; other lanes are ignored
  assign wr_en    = wr_fire & wlane0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= spc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_full_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_full_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wlane0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ==========================================================================
  // Control registers
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_ctrl_q <= spc_pkg::RST_SLEEP_CTRL;
      clk_gate0_q  <= spc_pkg::RST_CLK_GATE0;
      in_dis0_q    <= spc_pkg::RST_IN_DIS[PINS0-1:0];
      in_dis1_q    <= spc_pkg::RST_IN_DIS[PINS1-1:0];
      dbg_dis_q    <= spc_pkg::RST_MCU_CTRL[spc_pkg::DEBUG_DISABLE_BIT];
    end else if (wr_en) begin
      // Upper bits of the mode register are unimplemented and stay zero
      if (wr_sleep) begin
        sleep_ctrl_q <= {4'h0, wbyte_q[spc_pkg::SLEEP_MODE_MSB:spc_pkg::SLEEP_ARM_BIT]};
      end
      // Only the two-wire gate is held; the reserved bit never stores
      if (wr_gate) begin
        clk_gate0_q <= {wbyte_q[spc_pkg::GATE_TWO_WIRE_BIT], 7'h00};
      end
      if (wr_dis0) begin
        in_dis0_q <= wbyte_q[PINS0-1:0];
      end
      if (wr_dis1) begin
        in_dis1_q <= wbyte_q[PINS1-1:0];
      end
      if (wr_mcu) begin
        dbg_dis_q <= wbyte_q[spc_pkg::DEBUG_DISABLE_BIT];
      end
    end
  end

  // ==========================================================================
  // Sleep sequencer
  // ==========================================================================
  logic [2:0] sel_mode;
  logic       sel_arm;
  logic       sel_reserved;
  logic       enter_ok;

  assign sel_mode     = sleep_ctrl_q[spc_pkg::SLEEP_MODE_MSB:spc_pkg::SLEEP_MODE_LSB];
  assign sel_arm      = sleep_ctrl_q[spc_pkg::SLEEP_ARM_BIT];
  assign sel_reserved = (sel_mode == spc_pkg::MODE_RSVD_A) | (sel_mode == spc_pkg::MODE_RSVD_B);
  // Reserved codes are treated like an unarmed request: safer than guessing a mode
  assign enter_ok     = sleep_instr & sel_arm & ~sel_reserved;

  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    done_d  = 1'b0;
    case (state_q)
      spc_pkg::SPC_RUN: begin
        if (enter_ok) begin
          state_d = spc_pkg::SPC_SLEEP;
          mode_d  = sel_mode;
        end else if (sleep_instr) begin
          done_d = 1'b1;
        end
      end
      spc_pkg::SPC_SLEEP: begin
        if (wake_event) begin
          state_d = spc_pkg::SPC_RUN;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = spc_pkg::SPC_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= spc_pkg::SPC_RUN;
      mode_q  <= spc_pkg::MODE_IDLE;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      done_q  <= done_d;
    end
  end

  assign sleeping   = (state_q == spc_pkg::SPC_SLEEP);
  assign sleep_done = done_q;

  // ==========================================================================
  // Clock domains per mode
  // ==========================================================================
  logic m_idle;
  logic m_adcnr;
  logic m_standby;
  logic io_run;
  logic adc_run;
  logic deep_sleep;

  assign m_idle    = sleeping & (mode_q == spc_pkg::MODE_IDLE);
  assign m_adcnr   = sleeping & (mode_q == spc_pkg::MODE_ADC_NR);
  assign m_standby = sleeping & ((mode_q == spc_pkg::MODE_STANDBY) |
                                 (mode_q == spc_pkg::MODE_EXT_STANDBY));
  // Power-down and power-save fall through every term below and halt all but a debug-held main oscillator
  assign io_run     = ~sleeping | m_idle;
  assign adc_run    = ~sleeping | m_idle | m_adcnr;
  assign deep_sleep = sleeping & ~io_run & ~adc_run;

  assign debug_active = fuses.debug_enable_fuse & fuses.scan_port_enable_fuse & ~dbg_dis_q;

  assign clocks.cpu      = ~sleeping;
  assign clocks.flash    = ~sleeping;
  assign clocks.io       = io_run;
  assign clocks.adc      = adc_run;
  // Debug keeps the oscillator up even in power-down, at a real current cost
  assign clocks.main_osc = adc_run | m_standby | (sleeping & debug_active);

  // ==========================================================================
  // Analog helpers
  // ==========================================================================
  logic comp_on;
  logic bod_on;
  logic ext_pend;

  spc_conv_track u_conv_track (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .adc_enable       (adc_enable),
    .conv_start       (adc_conv_start),
    .extended_pending (ext_pend)
  );

  assign comp_on = comparator_enable & (~sleeping | m_idle | m_adcnr);
  assign bod_on  = (fuses.brownout_level_fuses != spc_pkg::BOD_LEVEL_OFF);

  // Converter power ignores sleep state entirely
  assign analog.adc_power        = adc_enable;
  assign analog.adc_extended     = ext_pend;
  assign analog.comparator_power = comp_on;
  // Reference follows the software enable of the comparator, not its sleep cut
  assign analog.vref_enable      = bod_on | (comparator_enable & comparator_uses_ref) |
                                   (adc_enable & adc_uses_ref);
  assign analog.brownout_run     = bod_on;
  assign analog.watchdog_run     = watchdog_enable;

  // ==========================================================================
  // Port pin input buffers
  // ==========================================================================
  spc_pin_gate #(
    .W (PINS0)
  ) u_pin_gate0 (
    .input_disable (in_dis0_q),
    .deep_sleep    (deep_sleep),
    .wake_needed   (wake_needed0),
    .buffer_enable (pin_buffer_en0)
  );

  spc_pin_gate #(
    .W (PINS1)
  ) u_pin_gate1 (
    .input_disable (in_dis1_q),
    .deep_sleep    (deep_sleep),
    .wake_needed   (wake_needed1),
    .buffer_enable (pin_buffer_en1)
  );

  // ==========================================================================
  // Two-wire interface gating
  // ==========================================================================
  logic twi_gated;

  assign twi_gated             = clk_gate0_q[spc_pkg::GATE_TWO_WIRE_BIT];
  // No reset to the peripheral on ungating: it resumes exactly where it froze
  assign two_wire_clock_en     = ~twi_gated & io_run;
  assign two_wire_access_block = twi_gated;

  // ==========================================================================
  // AXI4-Lite read path
  // ==========================================================================
  logic                        rvalid_q;
  logic [31:0]                 rdata_q;
  logic [1:0]                  rresp_q;
  logic                        ar_hs;
  logic [spc_pkg::ADDR_W-1:0]  raddr_al;
  logic [7:0]                  status_byte;
  logic [7:0]                  rd_byte;
  logic                        rd_hit;

  assign s_axi_arready = ~rvalid_q;
  assign ar_hs         = s_axi_arvalid & s_axi_arready;
  assign raddr_al      = {s_axi_araddr[spc_pkg::ADDR_W-1:2], 2'b00};

  assign status_byte = {two_wire_clock_en, analog.vref_enable, ext_pend, debug_active,
                        mode_q, sleeping};

  assign rd_hit  = (raddr_al == spc_pkg::OFF_SLEEP_CTRL) | (raddr_al == spc_pkg::OFF_CLK_GATE0) |
                   (raddr_al == spc_pkg::OFF_IN_DIS0) | (raddr_al == spc_pkg::OFF_IN_DIS1) |
                   (raddr_al == spc_pkg::OFF_MCU_CTRL) | (raddr_al == spc_pkg::OFF_STATUS);
  assign rd_byte = (raddr_al == spc_pkg::OFF_SLEEP_CTRL) ? sleep_ctrl_q :
                   (raddr_al == spc_pkg::OFF_CLK_GATE0)  ? clk_gate0_q :
                   (raddr_al == spc_pkg::OFF_IN_DIS0)    ? 8'(in_dis0_q) :
                   (raddr_al == spc_pkg::OFF_IN_DIS1)    ? 8'(in_dis1_q) :
                   (raddr_al == spc_pkg::OFF_MCU_CTRL)   ? {dbg_dis_q, 7'h00} :
                   (raddr_al == spc_pkg::OFF_STATUS)     ? status_byte : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= spc_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_hit ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : spc_top

`default_nettype wire

// ==== verification/spc_checker.sv ====
// Checker: port-level properties of the sleep and power control block
`timescale 1ns/100ps
`default_nettype none
module spc_checker #(parameter int PINS0 = 8) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire spc_pkg::spc_fuses_s fuses,
  input wire logic adc_enable,
  input wire logic watchdog_enable,
  input wire logic sleep_instr,
  input wire logic sleep_done,
  input wire spc_pkg::spc_clocks_s clocks,
  input wire spc_pkg::spc_analog_s analog,
  input wire logic [PINS0-1:0] pin_buffer_en0,
  input wire logic [PINS0-1:0] wake_needed0,
  input wire logic two_wire_clock_en,
  input wire logic two_wire_access_block,
  input wire logic debug_active,
  input wire logic sleeping
);
  // =========================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_ADC_ON: assert property (adc_enable |-> analog.adc_power) else $error("adc off");
  AST_EXT: assert property ($rose(adc_enable) |=> analog.adc_extended) else $error("no ext");
  AST_CMP: assert property (sleeping && !clocks.adc |-> !analog.comparator_power)
    else $error("comparator on");
  AST_BOD: assert property (analog.brownout_run ==
    (fuses.brownout_level_fuses != spc_pkg::BOD_LEVEL_OFF)) else $error("bod");
  AST_WDT: assert property (watchdog_enable |-> analog.watchdog_run) else $error("wdt");
  AST_PIN: assert property (!clocks.io && !clocks.adc |->
    (pin_buffer_en0 & ~wake_needed0) == '0) else $error("pin buffer on");
  AST_OSC: assert property (sleeping && debug_active |-> clocks.main_osc) else $error("osc");
  AST_DBG: assert property (!(fuses.debug_enable_fuse && fuses.scan_port_enable_fuse)
    |-> !debug_active) else $error("debug on");
  AST_ENTRY: assert property ($rose(sleeping) |-> $past(sleep_instr)) else $error("entry");
  AST_UNARM: assert property (sleep_instr && !sleeping |=> sleeping || sleep_done)
    else $error("no answer");
  AST_TWI: assert property (two_wire_access_block |-> !two_wire_clock_en)
    else $error("twi");
endmodule : spc_checker
bind spc_top spc_checker #(.PINS0(PINS0)) i_chk (.aclk, .aresetn, .fuses, .adc_enable,
  .watchdog_enable, .sleep_instr, .sleep_done, .clocks, .analog, .pin_buffer_en0,
  .wake_needed0, .two_wire_clock_en, .two_wire_access_block, .debug_active, .sleeping);
`default_nettype wire

// ==== verification/test_sleep_power_control.sv ====
// Testbench: register bus, sleep modes and keep-alive outputs
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_sleep_power_control;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, sleep_instr, wake_event, sleep_done, adc_enable, adc_uses_ref;
  logic adc_conv_start, comparator_enable, comparator_uses_ref, watchdog_enable;
  logic two_wire_clock_en, two_wire_access_block, debug_active, sleeping;
  logic [7:0] s_axi_awaddr, s_axi_araddr, wake_needed0, wake_needed1;
  logic [7:0] pin_buffer_en0, pin_buffer_en1;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  spc_pkg::spc_fuses_s fuses;
  spc_pkg::spc_clocks_s clocks;
  spc_pkg::spc_analog_s analog;
  int bad_count, checks, cyc, i, j, dv;
  int seed = 32'h3d0d;
  int rm[5];
  int msk[5] = '{8'h0f, 8'h80, 8'hff, 8'hff, 8'h80};
  logic [2:0] m;
  logic [4:0] ck;
  logic slp, dbg, deep, bod, vref;
  spc_top i_dut (.*);
  always #2.5 aclk = ~aclk;
  // Hang guard, far above the longest sequence
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // =========================================
  // Bus master
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
    @(posedge aclk);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    if (r == spc_pkg::RESP_OKAY && a < 8'h14) rm[a>>2] = d & msk[a>>2];
    do @(negedge aclk); while (!s_axi_bvalid);
    `CHK("bresp", r, s_axi_bresp)
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (!s_axi_rvalid);
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask : rd
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, sleep_instr, wake_event, adc_enable, adc_conv_start} = 0;
    {adc_uses_ref, comparator_enable, comparator_uses_ref, watchdog_enable} = 0;
    {s_axi_awaddr, s_axi_araddr, wake_needed0, wake_needed1, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    fuses = 5'h1f;
    rm = '{default: 0};
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    for (i = 0; i < 5; i++) rd(i * 4, 0, spc_pkg::RESP_OKAY);
    rd(8'h18, 0, spc_pkg::RESP_SLVERR);
    wr(8'h18, $random(seed), spc_pkg::RESP_SLVERR);
    wr(spc_pkg::OFF_CLK_GATE0, 32'hff, spc_pkg::RESP_OKAY);
    rd(spc_pkg::OFF_CLK_GATE0, 32'h80, spc_pkg::RESP_OKAY);
    `CHK("twi_en", 1'b0, two_wire_clock_en)
    `CHK("twi_block", 1'b1, two_wire_access_block)
    wr(spc_pkg::OFF_CLK_GATE0, 0, spc_pkg::RESP_OKAY);
    `CHK("twi_en", 1'b1, two_wire_clock_en)
    adc_uses_ref <= 1;
    // Second pass is the off-then-on case
    for (j = 0; j < 2; j++) begin
      @(posedge aclk) adc_enable <= 1;
      @(posedge aclk);
      @(negedge aclk) `CHK("ext", 1'b1, analog.adc_extended)
      `CHK("vref", 1'b1, analog.vref_enable)
      @(posedge aclk) adc_conv_start <= 1;
      @(posedge aclk) adc_conv_start <= 0;
      @(negedge aclk) `CHK("ext", 1'b0, analog.adc_extended)
      @(posedge aclk) adc_enable <= 0;
      @(negedge aclk) `CHK("vref", 1'b0, analog.vref_enable)
    end
    // Bit 4 arms, bit 3 sets the debug disable bit, bits 2..0 pick the mode
    for (i = 0; i < 32; i++) begin
      @(posedge aclk);
      fuses <= $random(seed);
      {comparator_enable, comparator_uses_ref, adc_uses_ref, watchdog_enable} <= $random(seed);
      {wake_needed0, wake_needed1} <= $random(seed);
      dv = $random(seed);
      wr(spc_pkg::OFF_MCU_CTRL, {i[3], 7'h0}, spc_pkg::RESP_OKAY);
      wr(spc_pkg::OFF_IN_DIS0, dv, spc_pkg::RESP_OKAY);
      wr(spc_pkg::OFF_IN_DIS1, dv >> 8, spc_pkg::RESP_OKAY);
      wr(spc_pkg::OFF_SLEEP_CTRL, (dv & ~32'hf) | ((i & 7) << 1) | i[4], spc_pkg::RESP_OKAY);
      rd(spc_pkg::OFF_SLEEP_CTRL, rm[0], spc_pkg::RESP_OKAY);
      @(posedge aclk) sleep_instr <= 1;
      @(posedge aclk) sleep_instr <= 0;
      @(negedge aclk);
      m = i[2:0];
      slp = i[4] && m != 4 && m != 5;
      dbg = fuses.debug_enable_fuse && fuses.scan_port_enable_fuse && !i[3];
      bod = fuses.brownout_level_fuses != 3'h7;
      vref = bod || (comparator_enable && comparator_uses_ref);
      ck = slp ? {2'b0, m == 0, m < 2, m < 2 || m > 5 || dbg} : 5'h1f;
      deep = !ck[2] && !ck[1];
      `CHK("sleeping", slp, sleeping)
      `CHK("done", !slp, sleep_done)
      `CHK("clocks", ck, clocks)
      `CHK("pins0", ~rm[2][7:0] & (deep ? wake_needed0 : 8'hff), pin_buffer_en0)
      `CHK("pins1", ~rm[3][7:0] & (deep ? wake_needed1 : 8'hff), pin_buffer_en1)
      `CHK("analog", {2'b0, comparator_enable && !(slp && m > 1), vref, bod, watchdog_enable},
        analog)
      `CHK("debug", dbg, debug_active)
      `CHK("twi_en", ck[2], two_wire_clock_en)
      if (slp) begin
        rd(spc_pkg::OFF_STATUS, {ck[2], vref, 1'b0, dbg, m, 1'b1}, spc_pkg::RESP_OKAY);
        @(posedge aclk) wake_event <= 1;
        @(posedge aclk) wake_event <= 0;
        @(negedge aclk) `CHK("sleeping", 1'b0, sleeping)
        `CHK("done", 1'b1, sleep_done)
      end
    end
    stop_test;
  end
endmodule : test_sleep_power_control
`default_nettype wire
